// file: rtl/rnm_addr_map.v
// Radio network settings and Modbus address mapping logic
//
// Overview of operation
// - Channel setting offers sixteen channels plus a disabled value.
// - Accept only nodes whose channel equals the station channel.
// - Reset selects disabled channel; disabled station talks to no node.
// - Advance press while editing steps the channel to the next; a valid channel write in that cycle wins.
// - Station and nodes need same channel and symbol rate to talk.
// - Symbol rate offers exactly 4.8K, 19.2K and 76.8K.
// - Refresh interval at most 20 s, 5 s, 1 s by rate.
// - Reset selects the middle symbol rate 19.2K.
// - Highest node number holds a value from 1 to 100.
// - Refuse nodes whose number exceeds the highest node number.
// - Reset sets highest node number to one.
// - Reset selects 19.2 K line rate; master must match it.
// - Base address range depends on the mapping mode.
// - Shared mode: base address 1 to 247 serves everything.
// - Per-node mode: base address at most 247 minus node count.
// - Per-node mode: node answers at base address plus node number.
// - Reset sets base device address to one.
// - Serial port takes binary RTU framing only, never ASCII.
// - Shared mode: station registers 1-10, then ten per node.
// - One stop bit with parity, two stop bits without.
// - Reset selects per-node address mode.
`timescale 1ns/100ps
`include "rnm_consts.vh"

module rnm_addr_map #(
  parameter CHAN_W = 5
) (
  input  wire         ref_clk,
  input  wire         reset,
  input  wire         chan_edit,
  input  wire         advance_btn,
  input  wire         set_chan_we,
  input  wire [4:0]   set_chan,
  input  wire         set_rate_we,
  input  wire [1:0]   set_rate,
  input  wire         set_hi_we,
  input  wire [6:0]   set_hi,
  input  wire         set_baud_we,
  input  wire [2:0]   set_baud,
  input  wire         set_par_we,
  input  wire [1:0]   set_par,
  input  wire         set_map_we,
  input  wire         set_map,
  input  wire         set_addr_we,
  input  wire [7:0]   set_addr,
  input  wire [6:0]   node_count,
  input  wire         node_chk,
  input  wire [6:0]   node_number,
  input  wire [4:0]   node_chan,
  input  wire [1:0]   node_rate,
  input  wire         req_chk,
  input  wire         req_ascii,
  input  wire [7:0]   req_addr,
  input  wire [15:0]  req_reg,
  output reg  [4:0]   radio_channel_select_ff,
  output reg  [1:0]   radio_symbol_rate_ff,
  output reg  [6:0]   highest_node_number_ff,
  output reg  [2:0]   line_rate_ff,
  output reg  [1:0]   parity_ff,
  output reg          two_stop_ff,
  output reg          address_mapping_select_ff,
  output reg  [7:0]   base_device_address_ff,
  output reg  [5:0]   refresh_max_s_ff,
  output reg          node_accept_ff,
  output reg          req_answer_ff,
  output reg  [6:0]   req_unit_ff,
  output reg  [15:0]  req_local_reg_ff
);

  ////////////////////////////////////////////////////////////////////////
  // Button synchroniser and edge detect
  reg        adv_s1_ff;
  reg        adv_s2_ff;
  reg        adv_s3_ff;
  wire       adv_press = adv_s2_ff & ~adv_s3_ff;

  always @(posedge ref_clk) begin
    if (reset) begin
      adv_s1_ff <= 1'b0;
      adv_s2_ff <= 1'b0;
      adv_s3_ff <= 1'b0;
    end else begin
      adv_s1_ff <= advance_btn;
      adv_s2_ff <= adv_s1_ff;
      adv_s3_ff <= adv_s2_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Address range limit
  wire       map_sel = set_map_we ? set_map : address_mapping_select_ff;
  wire [7:0] addr_ceiling =
    (map_sel == `RNM_MAP_SHARED) ? `RNM_ADDR_MAX
    : (`RNM_ADDR_MAX - {1'b0, node_count});
  wire [7:0] map_ceiling =
    (address_mapping_select_ff == `RNM_MAP_SHARED) ? `RNM_ADDR_MAX
    : (`RNM_ADDR_MAX - {1'b0, node_count});

  ////////////////////////////////////////////////////////////////////////
  // Settings
  reg [4:0] nxt_chan;

  always @* begin
    nxt_chan = radio_channel_select_ff;
    if (set_chan_we && set_chan <= `RNM_CHAN_MAX)
      nxt_chan = set_chan;
    else if (chan_edit && adv_press) begin
      if (radio_channel_select_ff == `RNM_CHAN_MAX)
        nxt_chan = `RNM_CHAN_OFF;
      else
        nxt_chan = radio_channel_select_ff + 5'h01;
    end
  end

  always @(posedge ref_clk) begin
    if (reset)
      radio_channel_select_ff <= `RNM_CHAN_OFF;
    else
      radio_channel_select_ff <= nxt_chan;
  end

  ////////////////////////////////////////////////////////////////////////
  // Radio symbol rate and refresh bound
  reg [1:0] nxt_rate;
  reg [5:0] nxt_refresh;

  always @* begin
    nxt_rate = radio_symbol_rate_ff;
    if (set_rate_we && set_rate <= `RNM_RATE_76K8)
      nxt_rate = set_rate;
  end

  always @* begin
    case (radio_symbol_rate_ff)
      `RNM_RATE_4K8:  nxt_refresh = `RNM_REFRESH_4K8_S;
      `RNM_RATE_19K2: nxt_refresh = `RNM_REFRESH_19K2_S;
      `RNM_RATE_76K8: nxt_refresh = `RNM_REFRESH_76K8_S;
      default:        nxt_refresh = `RNM_REFRESH_19K2_S;
    endcase
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      radio_symbol_rate_ff <= `RNM_RATE_19K2;
      refresh_max_s_ff     <= `RNM_REFRESH_19K2_S;
    end else begin
      radio_symbol_rate_ff <= nxt_rate;
      refresh_max_s_ff     <= nxt_refresh;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Highest accepted node number
  reg [6:0] nxt_hi;

  always @* begin
    nxt_hi = highest_node_number_ff;
    if (set_hi_we && set_hi >= `RNM_NODE_MIN && set_hi <= `RNM_NODE_MAX)
      nxt_hi = set_hi;
  end

  always @(posedge ref_clk) begin
    if (reset)
      highest_node_number_ff <= `RNM_NODE_MIN;
    else
      highest_node_number_ff <= nxt_hi;
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial line rate, parity and stop bits
  reg [2:0] nxt_baud;
  reg [1:0] nxt_par;
  reg       nxt_two_stop;

  always @* begin
    nxt_baud = line_rate_ff;
    if (set_baud_we && set_baud <= `RNM_BAUD_115200)
      nxt_baud = set_baud;
  end

  always @* begin
    nxt_par = parity_ff;
    if (set_par_we && set_par <= `RNM_PAR_ODD)
      nxt_par = set_par;
  end

  always @* begin
    nxt_two_stop = (parity_ff == `RNM_PAR_NONE);
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      line_rate_ff <= `RNM_BAUD_19200;
      parity_ff    <= `RNM_PAR_EVEN;
      two_stop_ff  <= 1'b0;
    end else begin
      line_rate_ff <= nxt_baud;
      parity_ff    <= nxt_par;
      two_stop_ff  <= nxt_two_stop;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mapping mode and base device address
  reg       nxt_map;
  reg [7:0] nxt_addr;

  always @* begin
    nxt_map = address_mapping_select_ff;
    if (set_map_we)
      nxt_map = set_map;
  end

  always @* begin
    nxt_addr = base_device_address_ff;
    if (set_addr_we && set_addr >= `RNM_ADDR_MIN
        && set_addr <= addr_ceiling)
      nxt_addr = set_addr;
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      address_mapping_select_ff <= `RNM_MAP_PER_NODE;
      base_device_address_ff    <= `RNM_ADDR_MIN;
    end else begin
      address_mapping_select_ff <= nxt_map;
      base_device_address_ff    <= nxt_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Node acceptance
  reg nxt_accept;

  always @* begin
    nxt_accept = node_chk
      && radio_channel_select_ff != `RNM_CHAN_OFF
      && node_chan == radio_channel_select_ff
      && node_rate == radio_symbol_rate_ff
      && node_number >= `RNM_NODE_MIN
      && node_number <= highest_node_number_ff;
  end

  always @(posedge ref_clk) begin
    if (reset)
      node_accept_ff <= 1'b0;
    else
      node_accept_ff <= nxt_accept;
  end

  ////////////////////////////////////////////////////////////////////////
  // Modbus request address decode
  wire [8:0]  addr_diff  = {1'b0, req_addr} - {1'b0, base_device_address_ff};
  wire        per_node   = address_mapping_select_ff == `RNM_MAP_PER_NODE;
  wire        node_hit   = per_node && !addr_diff[8]
                           && addr_diff[7:0] != 8'h00
                           && addr_diff[7:0] <= {1'b0, highest_node_number_ff}
                           && base_device_address_ff <= map_ceiling;
  wire        base_hit   = req_addr == base_device_address_ff;
  wire [15:0] reg_m1     = req_reg - 16'h0001;
  wire [15:0] shr_unit   = reg_m1 / `RNM_REGS_PER_UNIT;
  wire [15:0] shr_local  = reg_m1 - shr_unit * `RNM_REGS_PER_UNIT + 16'h0001;
  wire        shr_ok     = req_reg != 16'h0000
                           && shr_unit <= {9'h000, highest_node_number_ff};

  wire        shr_hit    = base_hit && !per_node && shr_ok;
  wire        own_hit    = base_hit && per_node;
  reg         nxt_answer;
  reg  [6:0]  nxt_unit;
  reg  [15:0] nxt_local;

  always @* begin
    nxt_answer = 1'b0;
    nxt_unit   = 7'h00;
    nxt_local  = req_reg;
    if (req_chk && !req_ascii) begin
      if (shr_hit) begin
        nxt_answer = 1'b1;
        nxt_unit   = shr_unit[6:0];
        nxt_local  = shr_local;
      end else if (own_hit) begin
        nxt_answer = 1'b1;
      end else if (node_hit) begin
        nxt_answer = 1'b1;
        nxt_unit   = addr_diff[6:0];
      end
    end
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      req_answer_ff    <= 1'b0;
      req_unit_ff      <= 7'h00;
      req_local_reg_ff <= 16'h0000;
    end else begin
      req_answer_ff    <= nxt_answer;
      req_unit_ff      <= nxt_unit;
      req_local_reg_ff <= nxt_local;
    end
  end

endmodule // rnm_addr_map

// file: rtl/rnm_consts.vh
// Constants for the radio network and Modbus address map block
`ifndef RNM_CONSTS_VH
`define RNM_CONSTS_VH
`define RNM_CHAN_OFF      5'h00
`define RNM_CHAN_MAX      5'h10
`define RNM_RATE_4K8      2'h0
`define RNM_RATE_19K2     2'h1
`define RNM_RATE_76K8     2'h2
`define RNM_REFRESH_4K8_S  6'h14
`define RNM_REFRESH_19K2_S 6'h05
`define RNM_REFRESH_76K8_S 6'h01
`define RNM_NODE_MIN      7'h01
`define RNM_NODE_MAX      7'h64
`define RNM_ADDR_MIN      8'h01
`define RNM_ADDR_MAX      8'hf7
`define RNM_MAP_PER_NODE  1'b0
`define RNM_MAP_SHARED    1'b1
`define RNM_BAUD_9600     3'h0
`define RNM_BAUD_19200    3'h1
`define RNM_BAUD_38400    3'h2
`define RNM_BAUD_57600    3'h3
`define RNM_BAUD_115200   3'h4
`define RNM_PAR_NONE      2'h0
`define RNM_PAR_EVEN      2'h1
`define RNM_PAR_ODD       2'h2
`define RNM_REGS_PER_UNIT 16'h000a
`define RNM_CLK_HZ        100000000
`endif

// file: testbench/rnm_checker.sv
// Port assertions for the address map block
`timescale 1ns/100ps
module rnm_checker (
  input       ref_clk,
  input       reset,
  input       req_chk,
  input       req_ascii,
  input [7:0] req_addr,
  input       req_answer_ff,
  input [7:0] base_device_address_ff,
  input       address_mapping_select_ff,
  input       node_chk,
  input [4:0] node_chan,
  input [1:0] node_rate,
  input [1:0] radio_symbol_rate_ff,
  input [6:0] node_number,
  input       node_accept_ff,
  input [4:0] radio_channel_select_ff,
  input [6:0] highest_node_number_ff,
  input [1:0] parity_ff,
  input       two_stop_ff
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_asc; req_chk && req_ascii |=> !req_answer_ff; endproperty
  a_asc: assert property (p_asc)
    else $error("ascii frame answered");
  property p_idle; !req_chk |=> !req_answer_ff; endproperty
  a_idle: assert property (p_idle)
    else $error("answer without request");
  property p_far; req_chk && address_mapping_select_ff &&
    req_addr != base_device_address_ff |=> !req_answer_ff; endproperty
  a_far: assert property (p_far)
    else $error("foreign address answered");
  property p_off; node_chk && radio_channel_select_ff == 5'h00
    |=> !node_accept_ff; endproperty
  a_off: assert property (p_off)
    else $error("node accepted while off");
  property p_chan; node_chk && node_chan != radio_channel_select_ff
    |=> !node_accept_ff; endproperty
  a_chan: assert property (p_chan)
    else $error("node on other channel accepted");
  property p_hi; node_chk && node_number > highest_node_number_ff
    |=> !node_accept_ff; endproperty
  a_hi: assert property (p_hi)
    else $error("node above highest accepted");
  property p_stop; $stable(parity_ff)[*2]
    |-> two_stop_ff == (parity_ff == 2'h0); endproperty
  a_stop: assert property (p_stop)
    else $error("stop bits wrong for parity");
  property p_one; node_accept_ff |-> $past(node_chk); endproperty
  a_one: assert property (p_one)
    else $error("accept without node check");
  property p_rate; node_chk && node_rate != radio_symbol_rate_ff
    |=> !node_accept_ff; endproperty
  a_rate: assert property (p_rate)
    else $error("node at other symbol rate accepted");
endmodule // rnm_checker
bind rnm_addr_map rnm_checker chk_i (.*);

// file: testbench/rnm_master.sv
// Modbus master model issuing request strobes
`timescale 1ns/100ps
module rnm_master (
  input             ref_clk,
  input             go,
  input             ascii,
  input      [7:0]  addr,
  input      [15:0] rgs,
  output reg        req_chk = 1'b0,
  output reg        req_ascii = 1'b0,
  output reg [7:0]  req_addr = 8'h00,
  output reg [15:0] req_reg = 16'h0000
);
  // Idle ascii, address and register lines toggle so stale values never look valid; req_chk stays low
  always @(posedge ref_clk) begin
    req_chk <= go;
    req_ascii <= go ? ascii : ~req_ascii;
    req_addr <= go ? addr : ~req_addr;
    req_reg <= go ? rgs : ~req_reg;
  end
endmodule // rnm_master

// file: testbench/testbench.sv
// Self-checking bench for the address map block
`timescale 1ns/100ps
module testbench;
  logic ref_clk = 0, reset = 1, chan_edit = 0, advance_btn = 0, go = 0;
  logic set_chan_we = 0, set_rate_we = 0, set_hi_we = 0, set_baud_we = 0;
  logic set_par_we = 0, set_map_we = 0, set_map = 0, set_addr_we = 0;
  logic node_chk = 0, asc = 0, req_chk, req_ascii, two_stop_ff;
  logic node_accept_ff, address_mapping_select_ff, req_answer_ff;
  logic [1:0] set_rate = 0, set_par = 0, node_rate = 0;
  logic [1:0] radio_symbol_rate_ff, parity_ff;
  logic [2:0] set_baud = 0, line_rate_ff;
  logic [4:0] set_chan = 0, node_chan = 0, ch, radio_channel_select_ff;
  logic [5:0] refresh_max_s_ff;
  logic [6:0] set_hi = 0, node_count = 0, node_number = 0, hi = 1;
  logic [6:0] highest_node_number_ff, req_unit_ff;
  logic [7:0] set_addr = 0, adr = 0, req_addr, base_device_address_ff;
  logic [15:0] rg = 0, req_reg, req_local_reg_ff;
  logic [31:0] sd = 32'hb13a46da;
  int n_fail = 0, compares = 0, i;
  always #5 ref_clk = ~ref_clk;
  rnm_addr_map dut (.*);
  rnm_master mst (.ref_clk(ref_clk), .go(go), .ascii(asc), .addr(adr),
    .rgs(rg), .req_chk(req_chk), .req_ascii(req_ascii),
    .req_addr(req_addr), .req_reg(req_reg));
  task tick; @(posedge ref_clk); #1; endtask
  task chk(input [15:0] g, e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task rq(input [7:0] a, input [15:0] r, input s, w, input [15:0] u, l);
    adr = a; rg = r; asc = s; go = 1;
    tick; go = 0; tick;
    chk(req_answer_ff, w);
    if (w) begin chk(req_unit_ff, u); chk(req_local_reg_ff, l); end
  endtask
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function acc(input [6:0] n, input [4:0] c, input [1:0] r);
    acc = ch != 0 && c == ch && r == 2'h2 && n != 0 && n <= hi;
  endfunction
  task wrap_up;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin #200000; n_fail++; wrap_up; end
  initial begin
    repeat (6) tick;
    reset = 0;
    tick;
    chk(radio_channel_select_ff, 16'h0);
    chk(radio_symbol_rate_ff, 16'h1);
    chk(highest_node_number_ff, 16'h1);
    chk(base_device_address_ff, 16'h1);
    chk(address_mapping_select_ff, 16'h0);
    set_chan_we = 1; set_chan = 5'h10; tick; set_chan = 5'h11; tick;
    set_chan_we = 0; tick;
    chk(radio_channel_select_ff, 16'h10);
    chan_edit = 1;
    for (i = 0; i < 2; i++) begin
      advance_btn = 1; repeat (4) tick; advance_btn = 0; repeat (2) tick;
      chk(radio_channel_select_ff, i[15:0]);
    end
    for (i = 0; i < 4; i++) begin
      {set_rate, set_par, set_baud} = {i[1:0], i[1:0], i[2:0]};
      {set_rate_we, set_par_we, set_baud_we} = 3'h7; tick;
      {set_rate_we, set_par_we, set_baud_we} = 3'h0; repeat (2) tick;
      chk(radio_symbol_rate_ff, i < 3 ? i : 2);
      chk(refresh_max_s_ff, i == 0 ? 20 : i == 1 ? 5 : 1);
      chk(two_stop_ff, i == 0);
      chk(line_rate_ff, i[15:0]);
      chk(parity_ff, i < 3 ? i : 2);
    end
    $display("settings test done");
    ch = 5'h01;
    for (i = 0; i < 60; i++) begin
      sd = lfsr(sd); set_hi = sd[6:0]; set_hi_we = 1; set_chan_we = i[0];
      set_chan = i < 4 ? 5'h00 : sd[12:8];
      if (set_hi >= 1 && set_hi <= 100) hi = set_hi;
      if (i[0] && set_chan <= 16) ch = set_chan;
      tick; set_hi_we = 0; set_chan_we = 0; node_chk = 1;
      node_number = sd[22:16]; node_chan = sd[13] ? ch : sd[28:24];
      node_rate = sd[14] ? 2'h2 : sd[31:30];
      tick; node_chk = 0;
      chk(highest_node_number_ff, hi);
      chk(node_accept_ff, acc(node_number, node_chan, node_rate));
    end
    $display("node test done");
    node_count = 7'h05; set_hi = 7'h64; set_hi_we = 1; set_addr_we = 1;
    set_addr = 8'hf3; tick; set_addr = 8'hf2; tick; set_hi_we = 0;
    set_addr_we = 0; tick;
    chk(base_device_address_ff, 16'hf2);
    set_addr_we = 1; set_addr = 8'h0a; tick; set_addr_we = 0; tick;
    rq(8'h0d, 16'h7, 0, 1, 16'h3, 16'h7);
    rq(8'h0d, 16'h7, 1, 0, 16'h0, 16'h0);
    rq(8'h09, 16'h1, 0, 0, 16'h0, 16'h0);
    rq(8'h0a, 16'h4, 0, 1, 16'h0, 16'h4);
    rq(8'h6f, 16'h1, 0, 0, 16'h0, 16'h0);
    set_map = 1; set_map_we = 1; set_addr_we = 1; set_addr = 8'hf7; tick;
    set_map_we = 0; set_addr_we = 0; tick;
    chk(base_device_address_ff, 16'hf7);
    rq(8'hf7, 16'hb, 0, 1, 16'h1, 16'h1);
    rq(8'hf7, 16'ha, 0, 1, 16'h0, 16'ha);
    rq(8'hf7, 16'h0, 0, 0, 16'h0, 16'h0);
    rq(8'hf6, 16'hb, 0, 0, 16'h0, 16'h0);
    $display("address test done");
    reset = 1; repeat (2) tick; reset = 0;
    chk(radio_channel_select_ff, 16'h0);
    chk(address_mapping_select_ff, 16'h0);
    set_chan_we = 1; set_chan = 5'h05; tick; set_chan_we = 0;
    node_chk = 1; node_number = 7'h01; node_chan = 5'h05;
    node_rate = 2'h1; tick;
    chk(node_accept_ff, 16'h1);
    node_rate = 2'h2; tick; node_chk = 0;
    chk(node_accept_ff, 16'h0);
    $display("reset test done");
    wrap_up;
  end
endmodule // testbench
